// ==== hdl/adcmp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Both operands multiplied by common signed gain
// - Signed offset added to each scaled operand
// - Output switched only by first minus second
// - On at least off: set above on, clear at or below off
// - On below off: high inside window only
// - On threshold constant clamped to plus/minus 20000, live block value not clamped
// - Off threshold constant clamped independently, same range
// - Either threshold may be another block's value
// - Decimals 0..3 only for display, not compare
// - Operand selector covers all analog source classes
module adcmp_top import adcmp_pkg::*; #(
  parameter int N_PHYS = 8,
  parameter int N_FLAG = 64,
  parameter int N_NIN = 32,
  parameter int N_AOUT = 8,
  parameter int N_NOUT = 16,
  parameter int N_BLK = 16,
  parameter int SCAN_CYCLES = SCAN_CYCLES_DEF
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [N_PHYS*PHYS_W-1:0] PHYS_ANALOG_INPUT_IN,
  input wire logic [N_FLAG*VAL_W-1:0] ANALOG_FLAG_IN,
  input wire logic [N_NIN*VAL_W-1:0] NETWORK_ANALOG_INPUT_IN,
  input wire logic [N_AOUT*VAL_W-1:0] ANALOG_OUTPUT_IN,
  input wire logic [N_NOUT*VAL_W-1:0] NETWORK_ANALOG_OUTPUT_IN,
  input wire logic [N_BLK*VAL_W-1:0] BLOCK_VALUE_IN,
  output logic COMPARE_OUT,
  output logic [VAL_W-1:0] DIFF_OUT,
  output logic SCAN_DONE_OUT,
  output logic [DEC_W-1:0] DECIMALS_OUT
);

  localparam int CNT_W = $clog2(SCAN_CYCLES + 1);
  localparam logic [CNT_W-1:0] SCAN_LAST = CNT_W'(SCAN_CYCLES - 1);

  logic run_q;
  logic signed [GAIN_W-1:0] gain_q;
  logic signed [GAIN_W-1:0] offset_q;
  logic signed [VAL_W-1:0] on_const_q;
  logic signed [VAL_W-1:0] off_const_q;
  logic [SEL_W-1:0] sel_first_q;
  logic [SEL_W-1:0] sel_second_q;
  logic on_live_q;
  logic off_live_q;
  logic [IDX_W-1:0] on_blk_q;
  logic [IDX_W-1:0] off_blk_q;
  logic [DEC_W-1:0] dec_q;
  logic [CNT_W-1:0] scan_cnt_q;
  logic scan_tick_q;
  logic eval_q;
  logic signed [VAL_W-1:0] op1_s_q;
  logic signed [VAL_W-1:0] op2_s_q;
  logic signed [VAL_W-1:0] on_s_q;
  logic signed [VAL_W-1:0] off_s_q;
  logic signed [VAL_W-1:0] diff_q;
  logic out_q;
  logic hyst_q;
  logic done_q;
  logic [31:0] prdata_q;
  logic signed [VAL_W-1:0] op1_val;
  logic signed [VAL_W-1:0] op2_val;
  logic signed [VAL_W-1:0] act1;
  logic signed [VAL_W-1:0] act2;
  logic signed [VAL_W-1:0] diff_d;
  logic signed [VAL_W-1:0] on_val;
  logic signed [VAL_W-1:0] off_val;
  logic signed [VAL_W-1:0] wr_val;
  logic addr_hit;
  logic wr_en;
  logic [31:0] rd_d;

  assign wr_val = PWDATA_IN;
  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;

  // Register decode
  always_comb
  begin
    addr_hit = 1'b1;
    rd_d = '0;
    unique case (PADDR_IN)
      ADDR_CTRL: rd_d[CTRL_RUN_BIT] = run_q;
      ADDR_GAIN: rd_d = 32'(signed'(gain_q));
      ADDR_OFFSET: rd_d = 32'(signed'(offset_q));
      ADDR_ON_THR: rd_d = on_const_q;
      ADDR_OFF_THR: rd_d = off_const_q;
      ADDR_OP_SEL:
      begin
        rd_d[OP_SEL_FIRST_LSB +: SEL_W] = sel_first_q;
        rd_d[OP_SEL_SECOND_LSB +: SEL_W] = sel_second_q;
      end
      ADDR_THR_SEL:
      begin
        rd_d[THR_SEL_ON_LSB +: IDX_W] = on_blk_q;
        rd_d[THR_SEL_ON_LIVE_BIT] = on_live_q;
        rd_d[THR_SEL_OFF_LSB +: IDX_W] = off_blk_q;
        rd_d[THR_SEL_OFF_LIVE_BIT] = off_live_q;
      end
      ADDR_DECIMALS: rd_d[DEC_W-1:0] = dec_q;
      ADDR_STATUS:
      begin
        rd_d[STATUS_OUT_BIT] = out_q;
        rd_d[STATUS_HYST_BIT] = hyst_q;
      end
      ADDR_DIFF: rd_d = diff_q;
      default: addr_hit = 1'b0;
    endcase
  end

  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_hit;

  // Read data captured in the setup phase
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      prdata_q <= '0;
    end
    else if (PSEL_IN && !PENABLE_IN)
    begin
      prdata_q <= rd_d;
    end
  end

  // Configuration writes, clamped to legal ranges
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      run_q <= 1'b0;
      gain_q <= GAIN_RESET;
      offset_q <= OFFSET_RESET;
      on_const_q <= THR_RESET;
      off_const_q <= THR_RESET;
      sel_first_q <= SEL_RESET;
      sel_second_q <= SEL_RESET;
      on_live_q <= 1'b0;
      off_live_q <= 1'b0;
      on_blk_q <= '0;
      off_blk_q <= '0;
      dec_q <= '0;
    end
    else if (wr_en)
    begin
      unique case (PADDR_IN)
        ADDR_CTRL: run_q <= PWDATA_IN[CTRL_RUN_BIT];
        ADDR_GAIN: gain_q <= GAIN_W'(adcmp_clamp(wr_val, GAIN_MIN, GAIN_MAX));
        ADDR_OFFSET: offset_q <= GAIN_W'(adcmp_clamp(wr_val, OFFSET_MIN, OFFSET_MAX));
        ADDR_ON_THR: on_const_q <= adcmp_clamp(wr_val, THR_MIN, THR_MAX);
        ADDR_OFF_THR: off_const_q <= adcmp_clamp(wr_val, THR_MIN, THR_MAX);
        ADDR_OP_SEL:
        begin
          sel_first_q <= PWDATA_IN[OP_SEL_FIRST_LSB +: SEL_W];
          sel_second_q <= PWDATA_IN[OP_SEL_SECOND_LSB +: SEL_W];
        end
        ADDR_THR_SEL:
        begin
          on_blk_q <= PWDATA_IN[THR_SEL_ON_LSB +: IDX_W];
          on_live_q <= PWDATA_IN[THR_SEL_ON_LIVE_BIT];
          off_blk_q <= PWDATA_IN[THR_SEL_OFF_LSB +: IDX_W];
          off_live_q <= PWDATA_IN[THR_SEL_OFF_LIVE_BIT];
        end
        ADDR_DECIMALS:
        begin
          // Display only, never reaches the compare path
          if (PWDATA_IN[31:DEC_W] != '0)
          begin
            dec_q <= DEC_MAX;
          end
          else
          begin
            dec_q <= PWDATA_IN[DEC_W-1:0];
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // Scan divider
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN || !run_q)
    begin
      scan_cnt_q <= '0;
      scan_tick_q <= 1'b0;
    end
    else if (scan_cnt_q == SCAN_LAST)
    begin
      scan_cnt_q <= '0;
      scan_tick_q <= 1'b1;
    end
    else
    begin
      scan_cnt_q <= scan_cnt_q + CNT_W'(1);
      scan_tick_q <= 1'b0;
    end
  end

  adcmp_src_sel #(
    .N_PHYS(N_PHYS),
    .N_FLAG(N_FLAG),
    .N_NIN(N_NIN),
    .N_AOUT(N_AOUT),
    .N_NOUT(N_NOUT),
    .N_BLK(N_BLK)
  ) u_sel_first (
    .phys_in(PHYS_ANALOG_INPUT_IN),
    .flag_in(ANALOG_FLAG_IN),
    .net_in_in(NETWORK_ANALOG_INPUT_IN),
    .aout_in(ANALOG_OUTPUT_IN),
    .net_out_in(NETWORK_ANALOG_OUTPUT_IN),
    .block_in(BLOCK_VALUE_IN),
    .sel_in(sel_first_q),
    .value_out(op1_val)
  );

  adcmp_src_sel #(
    .N_PHYS(N_PHYS),
    .N_FLAG(N_FLAG),
    .N_NIN(N_NIN),
    .N_AOUT(N_AOUT),
    .N_NOUT(N_NOUT),
    .N_BLK(N_BLK)
  ) u_sel_second (
    .phys_in(PHYS_ANALOG_INPUT_IN),
    .flag_in(ANALOG_FLAG_IN),
    .net_in_in(NETWORK_ANALOG_INPUT_IN),
    .aout_in(ANALOG_OUTPUT_IN),
    .net_out_in(NETWORK_ANALOG_OUTPUT_IN),
    .block_in(BLOCK_VALUE_IN),
    .sel_in(sel_second_q),
    .value_out(op2_val)
  );

  // Threshold source: constant or another block's live value
  always_comb
  begin
    on_val = on_const_q;
    off_val = off_const_q;
    if (on_live_q)
    begin
      on_val = '0;
      if (int'(on_blk_q) < N_BLK)
      begin
        on_val = BLOCK_VALUE_IN[int'(on_blk_q)*VAL_W +: VAL_W];
      end
    end
    if (off_live_q)
    begin
      off_val = '0;
      if (int'(off_blk_q) < N_BLK)
      begin
        off_val = BLOCK_VALUE_IN[int'(off_blk_q)*VAL_W +: VAL_W];
      end
    end
  end

  // Sample operands and thresholds at the scan tick
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      op1_s_q <= '0;
      op2_s_q <= '0;
      on_s_q <= '0;
      off_s_q <= '0;
      eval_q <= 1'b0;
    end
    else
    begin
      eval_q <= scan_tick_q;
      if (scan_tick_q)
      begin
        op1_s_q <= op1_val;
        op2_s_q <= op2_val;
        on_s_q <= on_val;
        off_s_q <= off_val;
      end
    end
  end

  adcmp_scale u_scale_first (
    .value_in(op1_s_q),
    .gain_in(gain_q),
    .offset_in(offset_q),
    .actual_out(act1)
  );

  adcmp_scale u_scale_second (
    .value_in(op2_s_q),
    .gain_in(gain_q),
    .offset_in(offset_q),
    .actual_out(act2)
  );

  assign diff_d = act1 - act2;

  // Output evaluation, plain integer compare
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      diff_q <= '0;
      out_q <= 1'b0;
      hyst_q <= 1'b1;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= eval_q;
      if (eval_q)
      begin
        diff_q <= diff_d;
        hyst_q <= (on_s_q >= off_s_q);
        if (on_s_q >= off_s_q)
        begin
          if (diff_d > on_s_q)
          begin
            out_q <= 1'b1;
          end
          else if (diff_d <= off_s_q)
          begin
            out_q <= 1'b0;
          end
          else
          begin
            out_q <= out_q;
          end
        end
        else
        begin
          out_q <= (diff_d >= on_s_q) && (diff_d < off_s_q);
        end
      end
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign COMPARE_OUT = out_q;
  assign DIFF_OUT = diff_q;
  assign SCAN_DONE_OUT = done_q;
  assign DECIMALS_OUT = dec_q;

endmodule // adcmp_top
`default_nettype wire

// ==== hdl/adcmp_pkg.sv ====
package adcmp_pkg;

  // Value and field widths
  localparam int VAL_W = 32;
  localparam int GAIN_W = 16;
  localparam int PHYS_W = 10;
  localparam int IDX_W = 7;
  localparam int CLS_W = 3;
  localparam int SEL_W = CLS_W + IDX_W;
  localparam int DEC_W = 2;
  localparam int ADDR_W = 12;
  localparam int PROD_W = VAL_W + GAIN_W;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_GAIN = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_ON_THR = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_OFF_THR = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_OP_SEL = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_THR_SEL = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_DECIMALS = 12'h01c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_DIFF = 12'h024;

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int OP_SEL_FIRST_LSB = 0;
  localparam int OP_SEL_SECOND_LSB = 16;
  localparam int THR_SEL_ON_LSB = 0;
  localparam int THR_SEL_ON_LIVE_BIT = 7;
  localparam int THR_SEL_OFF_LSB = 8;
  localparam int THR_SEL_OFF_LIVE_BIT = 15;
  localparam int STATUS_OUT_BIT = 0;
  localparam int STATUS_HYST_BIT = 1;

  // Ranges, gain in hundredths
  localparam logic signed [VAL_W-1:0] GAIN_MAX = 32'sh0000_03e8;
  localparam logic signed [VAL_W-1:0] GAIN_MIN = -32'sh0000_03e8;
  localparam logic signed [PROD_W-1:0] GAIN_SCALE = 48'sh0000_0000_0064;
  localparam logic signed [VAL_W-1:0] OFFSET_MAX = 32'sh0000_2710;
  localparam logic signed [VAL_W-1:0] OFFSET_MIN = -32'sh0000_2710;
  localparam logic signed [VAL_W-1:0] THR_MAX = 32'sh0000_4e20;
  localparam logic signed [VAL_W-1:0] THR_MIN = -32'sh0000_4e20;
  localparam logic [PHYS_W-1:0] PHYS_FULL = 10'h3e8;
  localparam logic [DEC_W-1:0] DEC_MAX = 2'h3;

  // Reset values
  localparam logic signed [GAIN_W-1:0] GAIN_RESET = 16'sh0064;
  localparam logic signed [GAIN_W-1:0] OFFSET_RESET = 16'sh0000;
  localparam logic signed [VAL_W-1:0] THR_RESET = 32'sh0000_0000;
  localparam logic [SEL_W-1:0] SEL_RESET = 10'h000;

  // Scan period in clock cycles
  localparam int SCAN_CYCLES_DEF = 200;

  typedef enum logic [CLS_W-1:0] {
    ADCMP_SRC_PHYS = 3'b000,
    ADCMP_SRC_FLAG = 3'b001,
    ADCMP_SRC_NET_IN = 3'b010,
    ADCMP_SRC_AOUT = 3'b011,
    ADCMP_SRC_NET_OUT = 3'b100,
    ADCMP_SRC_BLOCK = 3'b101
  } adcmp_src_t;

  function automatic logic signed [VAL_W-1:0] adcmp_clamp(
    input logic signed [VAL_W-1:0] v,
    input logic signed [VAL_W-1:0] lo,
    input logic signed [VAL_W-1:0] hi
  );
    if (v < lo)
    begin
      return lo;
    end
    else if (v > hi)
    begin
      return hi;
    end
    return v;
  endfunction

endpackage

// ==== hdl/adcmp_src_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcmp_src_sel import adcmp_pkg::*; #(
  parameter int N_PHYS = 8,
  parameter int N_FLAG = 64,
  parameter int N_NIN = 32,
  parameter int N_AOUT = 8,
  parameter int N_NOUT = 16,
  parameter int N_BLK = 16
) (
  input wire logic [N_PHYS*PHYS_W-1:0] phys_in,
  input wire logic [N_FLAG*VAL_W-1:0] flag_in,
  input wire logic [N_NIN*VAL_W-1:0] net_in_in,
  input wire logic [N_AOUT*VAL_W-1:0] aout_in,
  input wire logic [N_NOUT*VAL_W-1:0] net_out_in,
  input wire logic [N_BLK*VAL_W-1:0] block_in,
  input wire logic [SEL_W-1:0] sel_in,
  output logic signed [VAL_W-1:0] value_out
);

  logic [IDX_W-1:0] idx;
  logic [PHYS_W-1:0] raw;

  assign idx = sel_in[IDX_W-1:0];

  always_comb
  begin
    value_out = '0;
    raw = '0;
    unique case (sel_in[SEL_W-1:IDX_W])
      ADCMP_SRC_PHYS:
      begin
        if (int'(idx) < N_PHYS)
        begin
          raw = phys_in[int'(idx)*PHYS_W +: PHYS_W];
          // Full scale of a 0..10 V input is 1000
          if (raw > PHYS_FULL)
          begin
            raw = PHYS_FULL;
          end
          value_out = signed'(VAL_W'(raw));
        end
      end
      ADCMP_SRC_FLAG:
      begin
        if (int'(idx) < N_FLAG)
        begin
          value_out = flag_in[int'(idx)*VAL_W +: VAL_W];
        end
      end
      ADCMP_SRC_NET_IN:
      begin
        if (int'(idx) < N_NIN)
        begin
          value_out = net_in_in[int'(idx)*VAL_W +: VAL_W];
        end
      end
      ADCMP_SRC_AOUT:
      begin
        if (int'(idx) < N_AOUT)
        begin
          value_out = aout_in[int'(idx)*VAL_W +: VAL_W];
        end
      end
      ADCMP_SRC_NET_OUT:
      begin
        if (int'(idx) < N_NOUT)
        begin
          value_out = net_out_in[int'(idx)*VAL_W +: VAL_W];
        end
      end
      ADCMP_SRC_BLOCK:
      begin
        if (int'(idx) < N_BLK)
        begin
          value_out = block_in[int'(idx)*VAL_W +: VAL_W];
        end
      end
      default:
      begin
        value_out = '0;
      end
    endcase
  end

endmodule // adcmp_src_sel
`default_nettype wire

// ==== hdl/adcmp_scale.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcmp_scale import adcmp_pkg::*; (
  input wire logic signed [VAL_W-1:0] value_in,
  input wire logic signed [GAIN_W-1:0] gain_in,
  input wire logic signed [GAIN_W-1:0] offset_in,
  output logic signed [VAL_W-1:0] actual_out
);

  logic signed [PROD_W-1:0] val_ext;
  logic signed [PROD_W-1:0] gain_ext;
  logic signed [PROD_W-1:0] prod;
  logic signed [PROD_W-1:0] quo;
  logic signed [VAL_W-1:0] off_ext;

  assign val_ext = PROD_W'(value_in);
  assign gain_ext = PROD_W'(gain_in);
  assign off_ext = VAL_W'(offset_in);
  // Gain is in hundredths, quotient truncates toward zero
  assign prod = val_ext * gain_ext;
  assign quo = prod / GAIN_SCALE;
  assign actual_out = quo[VAL_W-1:0] + off_ext;

endmodule // adcmp_scale
`default_nettype wire

// ==== tb/adcmp_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcmp_top_checker import adcmp_pkg::*; #(
  parameter int SCAN_CYCLES = SCAN_CYCLES_DEF
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic COMPARE_OUT,
  input wire logic [VAL_W-1:0] DIFF_OUT,
  input wire logic SCAN_DONE_OUT,
  input wire logic [DEC_W-1:0] DECIMALS_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic acc;
  logic seen_q;
  logic [15:0] gap_q;
  assign acc = PSEL_IN && PENABLE_IN;
  // Cycles since the last result
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN || SCAN_DONE_OUT)
      gap_q <= 16'h0000;
    else
      gap_q <= gap_q + 16'h0001;
  end
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      seen_q <= 1'b0;
    else if (SCAN_DONE_OUT)
      seen_q <= 1'b1;
  end
  chk_pready_high: assert property (PREADY_OUT)
    else $error("pready low");
  chk_err_idle: assert property (!acc |-> !PSLVERR_OUT)
    else $error("slverr outside access");
  chk_err_unmapped: assert property (acc && PADDR_IN > ADDR_DIFF
    |-> PSLVERR_OUT && (PWRITE_IN || PRDATA_OUT == 32'h0))
    else $error("unmapped access not refused");
  chk_ok_mapped: assert property (acc && PADDR_IN <= ADDR_DIFF && PADDR_IN[1:0] == 2'h0
    |-> !PSLVERR_OUT)
    else $error("mapped access refused");
  chk_done_pulse: assert property (SCAN_DONE_OUT |=> !SCAN_DONE_OUT)
    else $error("done longer than one cycle");
  chk_scan_gap: assert property (SCAN_DONE_OUT && seen_q |-> gap_q >= 16'(SCAN_CYCLES - 1))
    else $error("scans too close");
  chk_out_hold: assert property (!SCAN_DONE_OUT && !$past(RESET_IN)
    |-> $stable(COMPARE_OUT) && $stable(DIFF_OUT))
    else $error("result changed between scans");
  chk_dec_write: assert property (acc && PWRITE_IN && PADDR_IN == ADDR_DECIMALS
    |=> DECIMALS_OUT == ($past(PWDATA_IN[31:2]) != 30'h0 ? DEC_MAX : $past(PWDATA_IN[1:0])))
    else $error("decimals not stored");
  chk_diff_read: assert property (acc && !PWRITE_IN && PADDR_IN == ADDR_DIFF
    && !SCAN_DONE_OUT |-> PRDATA_OUT == DIFF_OUT)
    else $error("diff read mismatch");
  chk_status_q: assert property (acc && !PWRITE_IN && PADDR_IN == ADDR_STATUS
    && !SCAN_DONE_OUT |-> PRDATA_OUT[STATUS_OUT_BIT] == COMPARE_OUT)
    else $error("status bit mismatch");
endmodule // adcmp_top_checker
bind adcmp_top adcmp_top_checker #(.SCAN_CYCLES(SCAN_CYCLES)) u_chk (.CLK_IN(CLK_IN),
  .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .COMPARE_OUT(COMPARE_OUT),
  .DIFF_OUT(DIFF_OUT), .SCAN_DONE_OUT(SCAN_DONE_OUT), .DECIMALS_OUT(DECIMALS_OUT));
`default_nettype wire

// ==== tb/adcmp_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcmp_src_model import adcmp_pkg::*; (
  input wire logic clk_in,
  output logic [8*PHYS_W-1:0] phys_out,
  output logic [64*VAL_W-1:0] flag_out,
  output logic [32*VAL_W-1:0] net_in_out,
  output logic [8*VAL_W-1:0] aout_out,
  output logic [16*VAL_W-1:0] net_out_out,
  output logic [16*VAL_W-1:0] block_out
);
  initial
  begin
    phys_out = '0;
    flag_out = '0;
    net_in_out = '0;
    aout_out = '0;
    net_out_out = '0;
    block_out = '0;
  end
  // Other blocks update their values at a clock edge
  task automatic set_val(input logic [CLS_W-1:0] cls, input int idx, input int v);
    @(posedge clk_in);
    case (cls)
      3'h0: phys_out[idx*PHYS_W+:PHYS_W] <= v[PHYS_W-1:0];
      3'h1: flag_out[idx*VAL_W+:VAL_W] <= v;
      3'h2: net_in_out[idx*VAL_W+:VAL_W] <= v;
      3'h3: aout_out[idx*VAL_W+:VAL_W] <= v;
      3'h4: net_out_out[idx*VAL_W+:VAL_W] <= v;
      default: block_out[idx*VAL_W+:VAL_W] <= v;
    endcase
  endtask
endmodule // adcmp_src_model
`default_nettype wire

// ==== tb/adcmp_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcmp_top_tb import adcmp_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, cmp, done, e, qe;
  logic [VAL_W-1:0] diff;
  logic [DEC_W-1:0] dec;
  logic [8*PHYS_W-1:0] v_phys;
  logic [64*VAL_W-1:0] v_flag;
  logic [32*VAL_W-1:0] v_nin;
  logic [8*VAL_W-1:0] v_aout;
  logic [16*VAL_W-1:0] v_nout, v_blk;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  initial
  begin
    forever #25 clk = ~clk;
  end
  adcmp_top #(.SCAN_CYCLES(4)) dut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .PHYS_ANALOG_INPUT_IN(v_phys), .ANALOG_FLAG_IN(v_flag), .NETWORK_ANALOG_INPUT_IN(v_nin),
    .ANALOG_OUTPUT_IN(v_aout), .NETWORK_ANALOG_OUTPUT_IN(v_nout), .BLOCK_VALUE_IN(v_blk),
    .COMPARE_OUT(cmp), .DIFF_OUT(diff), .SCAN_DONE_OUT(done), .DECIMALS_OUT(dec));
  adcmp_src_model u_src (.clk_in(clk), .phys_out(v_phys), .flag_out(v_flag),
    .net_in_out(v_nin), .aout_out(v_aout), .net_out_out(v_nout), .block_out(v_blk));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, response taken at the pready edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Waits for two results so new inputs are surely sampled
  task automatic scan2;
    int n, k;
    for (k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (done !== 1'b1 && n < 100);
      if (n >= 100)
        err_count++;
    end
  endtask
  function automatic int act(input int v, input int g, input int o);
    return (v * g) / 100 + o;
  endfunction
  initial
  begin
    int i;
    logic [ADDR_W-1:0] ra[10] = '{ADDR_CTRL, ADDR_GAIN, ADDR_OFFSET, ADDR_ON_THR, ADDR_OFF_THR,
      ADDR_OP_SEL, ADDR_THR_SEL, ADDR_DECIMALS, ADDR_STATUS, ADDR_DIFF};
    int rv[10] = '{0, 100, 0, 0, 0, 0, 0, 0, 2, 0};
    logic [ADDR_W-1:0] ca[5] = '{ADDR_GAIN, ADDR_GAIN, ADDR_OFFSET, ADDR_ON_THR, ADDR_OFF_THR};
    int cw[5] = '{2000, -2000, 20000, 30000, -30000};
    int ce[5] = '{1000, -1000, 10000, 20000, -20000};
    int ton[13] = '{10, 10, 10, 10, 10, 10, 10, -5, -5, -5, -5, 7, 7};
    int tof[13] = '{-10, -10, -10, -10, -10, -10, -10, 5, 5, 5, 5, 7, 7};
    int td[13] = '{-20, 5, 11, 10, -10, -9, 20, -6, -5, 4, 5, 7, 8};
    int lv2[3] = '{50, 70, 70};
    int lv3[3] = '{40, 40, 65};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 10; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", r, rv[i]);
    end
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped data", r, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    for (i = 0; i < 5; i++)
    begin
      wr(ca[i], cw[i]);
      apb(1'b0, ca[i], 32'h0);
      chk("clamped value", r, ce[i]);
    end
    wr(ADDR_DECIMALS, 32'h7);
    @(posedge clk);
    chk("decimals", {30'h0, dec}, 32'h3);
    wr(ADDR_DECIMALS, 32'h2);
    @(posedge clk);
    chk("decimals", {30'h0, dec}, 32'h2);
    $display("test registers done");
    u_src.set_val(3'h1, 3, 101);
    u_src.set_val(3'h0, 2, 40);
    wr(ADDR_OP_SEL, 32'h0002_0083);
    wr(ADDR_GAIN, -250);
    wr(ADDR_OFFSET, 37);
    wr(ADDR_ON_THR, 0);
    wr(ADDR_OFF_THR, 0);
    wr(ADDR_CTRL, 32'h1);
    scan2();
    chk("diff", diff, act(101, -250, 37) - act(40, -250, 37));
    apb(1'b0, ADDR_DIFF, 32'h0);
    chk("diff reg", r, act(101, -250, 37) - act(40, -250, 37));
    $display("test scaling done");
    wr(ADDR_GAIN, 100);
    wr(ADDR_OFFSET, 0);
    wr(ADDR_OP_SEL, 32'h0081_0080);
    for (i = 0; i < 13; i++)
    begin
      wr(ADDR_ON_THR, ton[i]);
      wr(ADDR_OFF_THR, tof[i]);
      u_src.set_val(3'h1, 0, td[i]);
      scan2();
      if (ton[i] >= tof[i])
        qe = (td[i] > ton[i]) ? 1'b1 : ((td[i] <= tof[i]) ? 1'b0 : qe);
      else
        qe = (td[i] >= ton[i] && td[i] < tof[i]);
      chk("compare", {31'h0, cmp}, {31'h0, qe});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status", r, {30'h0, ton[i] >= tof[i], qe});
    end
    $display("test thresholds done");
    for (i = 0; i < 6; i++)
      u_src.set_val(i, 1, (i == 0) ? 1023 : 100 * (i + 1) + 3);
    for (i = 0; i < 7; i++)
    begin
      wr(ADDR_OP_SEL, {16'h0300, 6'h00, i[2:0], 7'h01});
      scan2();
      chk("source", diff, (i == 0) ? 1000 : ((i == 6) ? 0 : 100 * (i + 1) + 3));
    end
    $display("test sources done");
    // Second operand from an unused class, so it reads zero
    wr(ADDR_OP_SEL, 32'h0300_0080);
    wr(ADDR_ON_THR, -20000);
    wr(ADDR_THR_SEL, 32'h0000_8382);
    u_src.set_val(3'h1, 0, 60);
    for (i = 0; i < 3; i++)
    begin
      u_src.set_val(3'h5, 2, lv2[i]);
      u_src.set_val(3'h5, 3, lv3[i]);
      scan2();
      chk("live threshold", {31'h0, cmp}, (i < 2) ? 32'h1 : 32'h0);
    end
    $display("test live thresholds done");
    wr(ADDR_CTRL, 32'h0);
    u_src.set_val(3'h1, 0, 500);
    // Let a scan already under way finish
    repeat (4) @(posedge clk);
    i = 0;
    repeat (20)
    begin
      @(posedge clk);
      if (done === 1'b1)
        i++;
    end
    chk("stopped scans", i, 32'h0);
    chk("held diff", diff, 32'd60);
    wr(ADDR_STATUS, 32'hffff_ffff);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status held", r, 32'h2);
    $display("test stop done");
    finish_test();
  end
endmodule // adcmp_top_tb
`default_nettype wire
